// ===== rtl/asbt_defs.svh
// Timing constants for the asynchronous SRAM controller.
`ifndef ASBT_DEFS_SVH
`define ASBT_DEFS_SVH
`define ASBT_CLK_PERIOD_PS 10000
`define ASBT_T_WC_PS 12000
`define ASBT_T_WP_PS 8000
`define ASBT_T_DW_PS 6000
`define ASBT_T_RC_PS 12000
`define ASBT_T_WHZ_PS 6000
`define ASBT_T_OW_PS 3000
`define ASBT_CYC_UP(t) (((t) + `ASBT_CLK_PERIOD_PS - 1) / `ASBT_CLK_PERIOD_PS)
`define ASBT_WP_CYC `ASBT_CYC_UP(`ASBT_T_WP_PS)
`define ASBT_RC_CYC `ASBT_CYC_UP(`ASBT_T_RC_PS)
`define ASBT_TURN_CYC 1
`endif

// ===== rtl/asbt_pkg.sv
// Types for the asynchronous SRAM controller.
package asbt_pkg;
	typedef enum logic [4:0] {
		ASBT_IDLE  = 5'h01,
		ASBT_RDLY  = 5'h02,
		ASBT_WSET  = 5'h04,
		ASBT_WPUL  = 5'h08,
		ASBT_TURN  = 5'h10
	} asbt_state_t;
endpackage

// ===== rtl/asbt_ctrl.sv
// Host-side controller driving a 256K x 16 asynchronous SRAM over its pins.
//------------------------------------------------------------------------------
// Behaviour
// - Write strobe stays high for the whole of every read.
// - Address is valid before or when chip select falls for a read.
// - A write cycle lasts at least the write cycle time.
// - Address, chip select and byte selects hold before end of write.
// - Write strobe stays low at least the write pulse width.
// - Write data is valid before end of write; removed a cycle after its end.
// - Address may change at start and end of write.
// - Address changes only while chip select or write strobe is high.
// - Controller never drives data pins while the memory drives them.
// - Output gate held high whenever the data pins must float.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`include "asbt_defs.svh"
module asbt_ctrl #(
	parameter int AW = 18,
	parameter int DW = 16
) (
	input  wire logic          SYS_CLK,
	input  wire logic          RST_N,
	input  wire logic          REQ_VALID,
	input  wire logic          REQ_WRITE,
	input  wire logic [AW-1:0] REQ_ADDR,
	input  wire logic [DW-1:0] REQ_WDATA,
	input  wire logic [1:0]    REQ_BE,
	output logic               REQ_READY,
	output logic               RD_VALID,
	output logic [DW-1:0]      RD_DATA,
	output logic [AW-1:0]      MEM_ADDR,
	output logic               MEM_CS_N,
	output logic               MEM_WE_N,
	output logic               MEM_OE_N,
	output logic               LOW_BYTE_SEL_N,
	output logic               HIGH_BYTE_SEL_N,
	input  wire logic [DW-1:0] DATA_PINS_IN,
	output logic [DW-1:0]      DATA_PINS_OUT,
	output logic               DATA_PINS_OE_N
);
	// Pulse and access lengths in whole clocks, rounded up for the slowest grade.
	// Faster parts work unchanged but gain no speed, so one build fits every grade.
	localparam logic [3:0] WP_CYC = 4'(`ASBT_WP_CYC);
	localparam logic [3:0] RC_CYC = 4'(`ASBT_RC_CYC);

	//--------------------------------------------------------------------------
	// Pin input synchroniser
	//--------------------------------------------------------------------------
	// The data pins settle on the memory's own timing, not on this clock.
	// Two flops guard against metastability at the price of two cycles a read.
	logic [DW-1:0] din_s1_ff, din_s2_ff;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			din_s1_ff <= '0;
			din_s2_ff <= '0;
		end else begin
			din_s1_ff <= DATA_PINS_IN;
			din_s2_ff <= din_s1_ff;
		end
	end

	//--------------------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------------------
	asbt_pkg::asbt_state_t state_ff, nxt_state;
	logic [3:0]    cnt_ff, nxt_cnt;
	logic [AW-1:0] addr_ff, nxt_addr;
	logic [DW-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic          cs_n_ff, nxt_cs_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
	logic          lb_n_ff, nxt_lb_n, ub_n_ff, nxt_ub_n, doe_n_ff, nxt_doe_n;
	logic          rdy_ff, nxt_rdy, rv_ff, nxt_rv;

	// Every pin comes from its own flop, so no combinational glitch reaches a pin.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_addr  = addr_ff;
		nxt_wd    = wd_ff;
		nxt_rd    = rd_ff;
		nxt_cs_n  = cs_n_ff;
		nxt_we_n  = we_n_ff;
		nxt_oe_n  = oe_n_ff;
		nxt_lb_n  = lb_n_ff;
		nxt_ub_n  = ub_n_ff;
		nxt_doe_n = doe_n_ff;
		nxt_rdy   = 1'b0;
		nxt_rv    = 1'b0;
		unique case (state_ff)
			asbt_pkg::ASBT_IDLE: begin
				nxt_rdy = 1'b1;
				if (REQ_VALID && rdy_ff) begin
					nxt_rdy  = 1'b0;
					// Address and chip select move together; strobe is high.
					nxt_addr = REQ_ADDR;
					nxt_cs_n = 1'b0;
					// Byte enables are high active here and low active at the pins.
					nxt_lb_n = ~REQ_BE[0];
					nxt_ub_n = ~REQ_BE[1];
					nxt_cnt  = 4'h0;
					if (REQ_WRITE) begin
						nxt_oe_n  = 1'b1;
						nxt_wd    = REQ_WDATA;
						nxt_state = asbt_pkg::ASBT_WSET;
					end else begin
						nxt_we_n  = 1'b1;
						nxt_oe_n  = 1'b0;
						nxt_doe_n = 1'b1;
						nxt_state = asbt_pkg::ASBT_RDLY;
					end
				end
			end
			asbt_pkg::ASBT_RDLY: begin
				// The memory's access time runs first, then the data crosses the flops.
				// Two extra cycles cover the pin synchroniser latency.
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == RC_CYC + 4'h2) begin
					nxt_rd    = din_s2_ff;
					nxt_rv    = 1'b1;
					nxt_cs_n  = 1'b1;
					nxt_oe_n  = 1'b1;
					nxt_lb_n  = 1'b1;
					nxt_ub_n  = 1'b1;
					nxt_cnt   = 4'h0;
					nxt_state = asbt_pkg::ASBT_TURN;
				end
			end
			asbt_pkg::ASBT_WSET: begin
				// Output gate has been high for a cycle, so the memory has let go.
				nxt_doe_n = 1'b0;
				nxt_we_n  = 1'b0;
				// The pins stay driven from here through the turnaround state, released on the edge that leaves it.
				nxt_state = asbt_pkg::ASBT_WPUL;
			end
			asbt_pkg::ASBT_WPUL: begin
				nxt_cnt = cnt_ff + 4'h1;
				// Strobe, selects and data all held to the pulse end.
				if (cnt_ff == WP_CYC) begin
					nxt_we_n  = 1'b1;
					nxt_cs_n  = 1'b1;
					nxt_lb_n  = 1'b1;
					nxt_ub_n  = 1'b1;
					nxt_cnt   = 4'h0;
					nxt_state = asbt_pkg::ASBT_TURN;
				end
			end
			asbt_pkg::ASBT_TURN: begin
				// Data released a cycle after end of write, keeping hold above zero.
				nxt_doe_n = 1'b1;
				nxt_state = asbt_pkg::ASBT_IDLE;
				nxt_rdy   = 1'b1;
				// A new request is taken no sooner than the edge after this one.
			end
			default: begin
				// An illegal state code parks every strobe high and returns to idle.
				nxt_state = asbt_pkg::ASBT_IDLE;
				nxt_cs_n  = 1'b1;
				nxt_we_n  = 1'b1;
				nxt_oe_n  = 1'b1;
				nxt_doe_n = 1'b1;
			end
		endcase
	end

	//--------------------------------------------------------------------------
	// Sequencer registers
	//--------------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= asbt_pkg::ASBT_IDLE;
			cnt_ff   <= 4'h0;
			addr_ff  <= '0;
			wd_ff    <= '0;
			rd_ff    <= '0;
			cs_n_ff  <= 1'b1;
			we_n_ff  <= 1'b1;
			oe_n_ff  <= 1'b1;
			lb_n_ff  <= 1'b1;
			ub_n_ff  <= 1'b1;
			doe_n_ff <= 1'b1;
			rdy_ff   <= 1'b0;
			rv_ff    <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			addr_ff  <= nxt_addr;
			wd_ff    <= nxt_wd;
			rd_ff    <= nxt_rd;
			cs_n_ff  <= nxt_cs_n;
			we_n_ff  <= nxt_we_n;
			oe_n_ff  <= nxt_oe_n;
			lb_n_ff  <= nxt_lb_n;
			ub_n_ff  <= nxt_ub_n;
			doe_n_ff <= nxt_doe_n;
			rdy_ff   <= nxt_rdy;
			rv_ff    <= nxt_rv;
		end
	end

	//--------------------------------------------------------------------------
	// Pin and status outputs
	//--------------------------------------------------------------------------
	assign REQ_READY       = rdy_ff;
	assign RD_VALID        = rv_ff;
	assign RD_DATA         = rd_ff;
	assign MEM_ADDR        = addr_ff;
	assign MEM_CS_N        = cs_n_ff;
	assign MEM_WE_N        = we_n_ff;
	assign MEM_OE_N        = oe_n_ff;
	assign LOW_BYTE_SEL_N  = lb_n_ff;
	assign HIGH_BYTE_SEL_N = ub_n_ff;
	assign DATA_PINS_OUT   = wd_ff;
	assign DATA_PINS_OE_N  = doe_n_ff;
endmodule

// ===== tb/asbt_ctrl_monitor.sv
// Checker for the pin protocol of the SRAM controller.
`timescale 1ns/1ps
module asbt_ctrl_monitor (
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	input wire logic [17:0] MEM_ADDR,
	input wire logic        MEM_CS_N,
	input wire logic        MEM_WE_N,
	input wire logic        MEM_OE_N,
	input wire logic        LOW_BYTE_SEL_N,
	input wire logic        HIGH_BYTE_SEL_N,
	input wire logic [15:0] DATA_PINS_OUT,
	input wire logic        DATA_PINS_OE_N
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	a_read_we_high: assert property
		(!MEM_OE_N |-> MEM_WE_N) else $error("we low");
	a_addr_at_sel: assert property
		(!MEM_CS_N && $past(!MEM_CS_N) |-> $stable(MEM_ADDR)) else $error("addr moved");
	a_write_cyc_len: assert property
		($fell(MEM_CS_N) && MEM_OE_N |-> !MEM_CS_N [*3] ##1 MEM_CS_N) else $error("write cycle");
	a_we_pulse_len: assert property
		($fell(MEM_WE_N) |=> !MEM_WE_N ##1 MEM_WE_N) else $error("we pulse");
	a_cs_in_write: assert property
		(!MEM_WE_N |-> !MEM_CS_N) else $error("cs high");
	a_sel_in_write: assert property
		(!MEM_WE_N |-> $stable({LOW_BYTE_SEL_N, HIGH_BYTE_SEL_N}) && $stable(MEM_ADDR))
		else $error("select moved in write");
	a_data_in_write: assert property
		(!MEM_WE_N |-> !DATA_PINS_OE_N) else $error("no data");
	a_wdata_stable: assert property
		(!MEM_WE_N |-> $stable(DATA_PINS_OUT)) else $error("data moved in write");
	a_data_hold: assert property
		($rose(MEM_WE_N) |-> !DATA_PINS_OE_N) else $error("data gone at end of write");
	a_addr_change: assert property
		($changed(MEM_ADDR) |-> MEM_CS_N || MEM_WE_N) else $error("addr in write");
	a_no_contend: assert property
		(!DATA_PINS_OE_N |-> MEM_OE_N) else $error("contention");
	a_oe_in_write: assert property
		(!MEM_WE_N |-> MEM_OE_N) else $error("gate low in write");
	c_write: cover property ($fell(MEM_WE_N));
	c_read: cover property ($fell(MEM_OE_N));
	c_back: cover property ($rose(MEM_CS_N) ##[1:3] $fell(MEM_CS_N));
	c_no_lane: cover property (!MEM_WE_N && LOW_BYTE_SEL_N && HIGH_BYTE_SEL_N);
endmodule
bind asbt_ctrl asbt_ctrl_monitor u_mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MEM_ADDR(MEM_ADDR),
	.MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N),
	.LOW_BYTE_SEL_N(LOW_BYTE_SEL_N), .HIGH_BYTE_SEL_N(HIGH_BYTE_SEL_N),
	.DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE_N(DATA_PINS_OE_N));

// ===== tb/asbt_sram_model.sv
// Behavioural model of the 256K x 16 asynchronous SRAM.
`timescale 1ns/1ps
module asbt_sram_model (
	input wire logic [17:0] addr,
	input wire logic        cs_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic        lb_n,
	input wire logic        ub_n,
	input wire logic [15:0] din,
	output logic     [15:0] dq
);
	logic [15:0] mem [0:262143];
	logic [15:0] flt = 16'h5A3C;
	// No pull resistor on the pins, so a floating lane shows a moving pattern.
	always #5 flt = ~flt;
	always @(cs_n, we_n, lb_n, ub_n, addr, din) if (!cs_n && !we_n) begin
		if (!lb_n) mem[addr][7:0] = din[7:0];
		if (!ub_n) mem[addr][15:8] = din[15:8];
	end
	wire rd = !cs_n && !oe_n && we_n;
	assign dq = {(rd && !ub_n) ? mem[addr][15:8] : flt[15:8],
		(rd && !lb_n) ? mem[addr][7:0] : flt[7:0]};
endmodule

// ===== tb/test_async_sram_bus_timing.sv
// Self-checking bench for the asynchronous SRAM controller.
`timescale 1ns/1ps
module test_async_sram_bus_timing;
	logic SYS_CLK = 0, RST_N = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_READY, RD_VALID;
	logic MEM_CS_N, MEM_WE_N, MEM_OE_N, LOW_BYTE_SEL_N, HIGH_BYTE_SEL_N, DATA_PINS_OE_N;
	logic [17:0] REQ_ADDR = 0, MEM_ADDR;
	logic [15:0] REQ_WDATA = 0, RD_DATA, DATA_PINS_OUT, dq;
	logic [1:0]  REQ_BE = 0;
	int          errors, checked, cyc;
	wire [15:0]  DATA_PINS_IN = DATA_PINS_OE_N ? dq : DATA_PINS_OUT;
	asbt_ctrl uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_BE(REQ_BE), .REQ_READY(REQ_READY),
		.RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MEM_ADDR(MEM_ADDR), .MEM_CS_N(MEM_CS_N),
		.MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N), .LOW_BYTE_SEL_N(LOW_BYTE_SEL_N),
		.HIGH_BYTE_SEL_N(HIGH_BYTE_SEL_N), .DATA_PINS_IN(DATA_PINS_IN),
		.DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE_N(DATA_PINS_OE_N));
	asbt_sram_model sram (.addr(MEM_ADDR), .cs_n(MEM_CS_N), .we_n(MEM_WE_N), .oe_n(MEM_OE_N),
		.lb_n(LOW_BYTE_SEL_N), .ub_n(HIGH_BYTE_SEL_N), .din(DATA_PINS_IN), .dq(dq));
	initial forever #5 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) if (++cyc == 500) begin
		errors++;
		end_of_test();
	end
	task chk(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task req(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] b);
		@(posedge SYS_CLK);
		#1 {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_BE} = {1'b1, w, a, d, b};
		while (REQ_READY !== 1'b1) @(negedge SYS_CLK);
		@(posedge SYS_CLK);
		#1 REQ_VALID = 0;
	endtask
	task rd(input logic [17:0] a, input logic [1:0] b, input logic [15:0] e, m);
		req(0, a, 0, b);
		repeat (8) if (RD_VALID !== 1'b1) @(negedge SYS_CLK);
		chk({15'h0, RD_VALID}, 16'h1);
		chk(RD_DATA & m, e & m);
	endtask
	task t_word;
		req(1, 18'h3FFFF, 16'h1234, 2'h3);
		req(1, 18'h00000, 16'hABCD, 2'h3);
		rd(18'h3FFFF, 2'h3, 16'h1234, 16'hFFFF);
		rd(18'h00000, 2'h3, 16'hABCD, 16'hFFFF);
		$display("test word done");
	endtask
	task t_lanes;
		req(1, 18'h00005, 16'h1122, 2'h1);
		req(1, 18'h00005, 16'h3344, 2'h2);
		req(1, 18'h00005, 16'h5566, 2'h0);
		rd(18'h00005, 2'h3, 16'h3322, 16'hFFFF);
		rd(18'h00005, 2'h1, 16'h0022, 16'h00FF);
		rd(18'h00005, 2'h2, 16'h3300, 16'hFF00);
		$display("test lanes done");
	endtask
	task t_reset;
		@(posedge SYS_CLK);
		#1 RST_N = 0;
		@(negedge SYS_CLK);
		chk({11'h0, REQ_READY, MEM_CS_N, MEM_WE_N, MEM_OE_N, DATA_PINS_OE_N}, 16'h000F);
		@(posedge SYS_CLK);
		#1 RST_N = 1;
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk({11'h0, REQ_READY, MEM_CS_N, MEM_WE_N, MEM_OE_N, DATA_PINS_OE_N}, 16'h001F);
		rd(18'h3FFFF, 2'h3, 16'h1234, 16'hFFFF);
		$display("test reset done");
	endtask
	task end_of_test;
		$display("compares %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge SYS_CLK);
		#1 RST_N = 1;
		t_word();
		t_lanes();
		t_reset();
		end_of_test();
	end
endmodule
